// ===== prtc_pkg.sv
// Package of constants and carrier types for the PHY control register bank
// Overview of operation
// - First control register at 0x9, resets zero
// - Second control register at 0xA, resets zero
// - Autorun bit starts cable test after link-down
// - Robust crossover bit enables crossover resolution
// - Normal mode: receive valid after full J K
// - Early mode: receive valid on J alone
// - Early mode: J without K raises receive error
// - Forced-partner bit forces full duplex link, unless local is forced to other than 100TX
// - Bit clear: standard duplex resolution only
// - Idle symbol error bit enables idle error flag
// - Odd nibble check on: extend enable, error
// - Odd nibble check off: no extend, no error
package prtc_pkg;
	localparam int ADDR_W = 5; // Management register address width
	localparam int DATA_W = 16; // Register width
	localparam logic [4:0] OFS_CONTROL_ONE = 5'h09; // First control register
	localparam logic [4:0] OFS_CONTROL_TWO = 5'h0A; // Second control register
	localparam logic [15:0] RST_CONTROL = 16'h0000; // Reset value of both
	localparam int B1_AUTORUN = 8; // Cable test autorun enable
	localparam int B1_ROBUST = 5; // Robust crossover enable
	localparam int B1_EARLY_RXDV = 1; // Early receive-valid enable
	localparam int B2_EXT_FDX = 5; // Forced-partner full duplex enable
	localparam int B2_IDLE_ERR = 2; // Idle symbol error detect enable
	localparam int B2_ODD_OFF = 1; // Odd-nibble check disable
	localparam logic [15:0] MASK_ONE = 16'h0122; // Writable bits, first reg
	localparam logic [15:0] MASK_TWO = 16'h0026; // Writable bits, second reg
	// Receive symbol classes handed in by the decoder
	typedef enum logic [2:0] {
		PRTC_SYM_IDLE, PRTC_SYM_J, PRTC_SYM_K, PRTC_SYM_DATA,
		PRTC_SYM_END, PRTC_SYM_BAD
	} prtc_sym_t;
	// Feature enables decoded from the registers
	typedef struct packed {
		logic autorun;
		logic robust;
		logic early_rxdv;
		logic ext_fdx;
		logic idle_err;
		logic odd_off;
	} prtc_cfg_t;
	// Transmit enable and error as seen by the coder
	typedef struct packed {
		logic en;
		logic er;
	} prtc_tx_t;
endpackage : prtc_pkg

// ===== prtc_tx_odd.sv
// Transmit enable odd-nibble extension stage
`timescale 1ns/10ps
module prtc_tx_odd (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic odd_off,
	input wire logic tx_en,
	input wire logic tx_er,
	output prtc_pkg::prtc_tx_t tx_out
);
	logic odd_r; // High after an odd count of nibbles
	logic en_d_r; // Enable of previous cycle
	logic er_d_r; // MAC error of previous cycle, kept in step with en_d_r
	logic ext_r; // Extra cycle is in progress
	logic drop_odd; // Enable falls on an odd boundary

	assign drop_odd = en_d_r && !tx_en && odd_r && !odd_off;

	// Nibble parity counts within the frame; error delayed alongside
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			odd_r <= 1'b0;
			en_d_r <= 1'b0;
			er_d_r <= 1'b0;
		end else begin
			en_d_r <= tx_en;
			er_d_r <= tx_er;
			odd_r <= tx_en ? !odd_r : 1'b0;
		end
	end

	// One extra cycle flagged as error; disabled check passes through
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			ext_r <= 1'b0;
		end else begin
			ext_r <= drop_odd;
		end
	end

	// Registered output: two cycles behind tx_en so the extension fits
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_out <= '0;
		end else begin
			tx_out.en <= en_d_r || ext_r;
			// MAC error passes only inside its own enable window
			tx_out.er <= ext_r || (er_d_r && en_d_r);
		end
	end

	// Extension only when check enabled
	a_odd_extend: assert property (@(posedge clock) disable iff (!rst_b)
		drop_odd |=> ##1 (tx_out.en && tx_out.er))
		else $error("odd nibble drop not extended");
	a_odd_off: assert property (@(posedge clock) disable iff (!rst_b)
		odd_off && $past(odd_off) |-> !ext_r)
		else $error("extension while check disabled");
endmodule : prtc_tx_odd

// ===== prtc_ctrl.sv
// Control register bank with receive, transmit and duplex feature logic
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
module prtc_ctrl (
	input wire logic CLOCK,
	input wire logic RST_B,
	input wire logic [prtc_pkg::ADDR_W-1:0] ADDR,
	input wire logic [prtc_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [prtc_pkg::DATA_W-1:0] RDATA,
	input wire logic LINK_UP,
	output logic CABLE_TEST_START,
	output logic ROBUST_CROSSOVER_EN,
	input wire logic FORCED_MODE,
	input wire logic LOCAL_100TX,
	input wire logic PARTNER_FORCED_100TX,
	input wire logic IEEE_FULL_DUPLEX,
	output logic FULL_DUPLEX,
	input wire logic SYM_VALID,
	input wire prtc_pkg::prtc_sym_t SYM,
	output logic RX_DV,
	output logic RX_ER,
	input wire logic TX_EN_IN,
	input wire logic TX_ER_IN,
	output logic TX_EN_OUT,
	output logic TX_ER_OUT
);
	logic [15:0] control_one_r; // First control register
	logic [15:0] control_two_r; // Second control register
	prtc_pkg::prtc_cfg_t cfg; // Decoded enables
	prtc_pkg::prtc_tx_t tx_q; // Transmit stage output
	logic link_d_r; // Link state of previous cycle
	logic link_down; // Link fell this cycle
	logic rx_dv_r; // Receive valid flop
	logic rx_er_r; // Receive error flop
	logic fdx_r; // Duplex flop
	logic test_r; // Cable test start pulse

	// Receive framing states
	typedef enum logic [1:0] {
		PRTC_RX_IDLE, PRTC_RX_GOT_J, PRTC_RX_FRAME
	} prtc_rx_state_t;
	prtc_rx_state_t rx_state_r;
	prtc_rx_state_t rx_state_nxt;

	// Masking write data keeps reserved bits at zero forever
	function automatic logic [15:0] wmask(input logic [15:0] d,
		input logic [15:0] m);
		wmask = d & m;
	endfunction : wmask

	// Register writes; only writable bits are stored
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			control_one_r <= prtc_pkg::RST_CONTROL;
			control_two_r <= prtc_pkg::RST_CONTROL;
		end else if (WR) begin
			if (ADDR == prtc_pkg::OFS_CONTROL_ONE) begin
				// Reserved bits dropped on write
				control_one_r <= wmask(WDATA, prtc_pkg::MASK_ONE);
			end
			if (ADDR == prtc_pkg::OFS_CONTROL_TWO) begin
				control_two_r <= wmask(WDATA, prtc_pkg::MASK_TWO);
			end
		end
	end

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			RDATA <= '0;
		end else if (RD) begin
			case (ADDR)
				prtc_pkg::OFS_CONTROL_ONE: begin
					RDATA <= wmask(control_one_r, prtc_pkg::MASK_ONE);
				end
				prtc_pkg::OFS_CONTROL_TWO: begin
					RDATA <= wmask(control_two_r, prtc_pkg::MASK_TWO);
				end
				default: begin
					RDATA <= '0; // Unmapped reads return zero
				end
			endcase
		end else begin
			RDATA <= '0;
		end
	end

	// Decode enables
	always_comb begin
		cfg.autorun = control_one_r[prtc_pkg::B1_AUTORUN];
		cfg.robust = control_one_r[prtc_pkg::B1_ROBUST];
		cfg.early_rxdv = control_one_r[prtc_pkg::B1_EARLY_RXDV];
		cfg.ext_fdx = control_two_r[prtc_pkg::B2_EXT_FDX];
		cfg.idle_err = control_two_r[prtc_pkg::B2_IDLE_ERR];
		cfg.odd_off = control_two_r[prtc_pkg::B2_ODD_OFF];
	end

	// Crossover resolver enable; software must set it when forcing
	assign ROBUST_CROSSOVER_EN = cfg.robust;

	// Link-down edge detector
	assign link_down = link_d_r && !LINK_UP;

	// Cable test start pulse, one cycle per link-down event while autorun is set
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			link_d_r <= 1'b0;
			test_r <= 1'b0;
		end else begin
			link_d_r <= LINK_UP;
			test_r <= link_down && cfg.autorun;
		end
	end
	assign CABLE_TEST_START = test_r;

	// Duplex choice: forced partner at 100TX overrides when enabled, unless local is forced to other than 100TX
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			fdx_r <= 1'b0;
		end else if (cfg.ext_fdx && PARTNER_FORCED_100TX &&
			(!FORCED_MODE || LOCAL_100TX)) begin
			fdx_r <= 1'b1;
		end else begin
			fdx_r <= IEEE_FULL_DUPLEX;
		end
	end
	assign FULL_DUPLEX = fdx_r;

	// Receive framing next state
	always_comb begin
		rx_state_nxt = rx_state_r;
		if (SYM_VALID) begin
			case (rx_state_r)
				PRTC_RX_IDLE: begin
					if (SYM == prtc_pkg::PRTC_SYM_J) begin
						rx_state_nxt = PRTC_RX_GOT_J;
					end
				end
				PRTC_RX_GOT_J: begin
					if (SYM == prtc_pkg::PRTC_SYM_K) begin
						rx_state_nxt = PRTC_RX_FRAME;
					end else begin
						rx_state_nxt = PRTC_RX_IDLE; // False start
					end
				end
				PRTC_RX_FRAME: begin
					if (SYM == prtc_pkg::PRTC_SYM_END ||
						SYM == prtc_pkg::PRTC_SYM_IDLE) begin
						rx_state_nxt = PRTC_RX_IDLE;
					end
				end
				default: begin
					rx_state_nxt = PRTC_RX_IDLE;
				end
			endcase
		end
	end

	// Receive state register
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rx_state_r <= PRTC_RX_IDLE;
		end else begin
			rx_state_r <= rx_state_nxt;
		end
	end

	// Receive valid: early on J, else after J K
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rx_dv_r <= 1'b0;
		end else if (rx_state_nxt == PRTC_RX_FRAME) begin
			rx_dv_r <= 1'b1;
		end else if (rx_state_nxt == PRTC_RX_GOT_J) begin
			rx_dv_r <= cfg.early_rxdv;
		end else begin
			rx_dv_r <= 1'b0;
		end
	end
	assign RX_DV = rx_dv_r;

	// Receive error: false start in early mode, idle symbol error, or bad symbol in frame
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			rx_er_r <= 1'b0;
		end else if (SYM_VALID && rx_state_r == PRTC_RX_GOT_J &&
			SYM != prtc_pkg::PRTC_SYM_K && rx_dv_r) begin
			rx_er_r <= 1'b1;
		end else if (SYM_VALID && rx_state_r == PRTC_RX_IDLE &&
			SYM == prtc_pkg::PRTC_SYM_BAD) begin
			rx_er_r <= cfg.idle_err;
		end else if (SYM_VALID && rx_state_r == PRTC_RX_FRAME &&
			SYM == prtc_pkg::PRTC_SYM_BAD) begin
			rx_er_r <= 1'b1; // In-frame errors always flagged
		end else begin
			rx_er_r <= 1'b0;
		end
	end
	assign RX_ER = rx_er_r;

	// Transmit odd-nibble stage
	prtc_tx_odd u_tx (
		.clock(CLOCK),
		.rst_b(RST_B),
		.odd_off(cfg.odd_off),
		.tx_en(TX_EN_IN),
		.tx_er(TX_ER_IN),
		.tx_out(tx_q)
	);
	// The stage delays the MAC error itself, so it stays aligned with enable
	assign TX_EN_OUT = tx_q.en;
	assign TX_ER_OUT = tx_q.er;

	a_reg_one_reset: assert property (@(posedge CLOCK) disable iff (!RST_B)
		$rose(RST_B) |-> control_one_r == prtc_pkg::RST_CONTROL)
		else $error("first register not reset");
	a_reg_two_reset: assert property (@(posedge CLOCK) disable iff (!RST_B)
		$rose(RST_B) |-> control_two_r == prtc_pkg::RST_CONTROL)
		else $error("second register not reset");
	a_autorun_pulse: assert property (@(posedge CLOCK) disable iff (!RST_B)
		test_r |-> $past(link_down) && $past(cfg.autorun))
		else $error("cable test start without cause");
	a_robust_follow: assert property (@(posedge CLOCK) disable iff (!RST_B)
		ROBUST_CROSSOVER_EN == control_one_r[prtc_pkg::B1_ROBUST])
		else $error("crossover enable mismatch");
	a_normal_dv_late: assert property (@(posedge CLOCK) disable iff (!RST_B)
		$rose(rx_dv_r) && !$past(cfg.early_rxdv)
		|-> rx_state_r == PRTC_RX_FRAME)
		else $error("receive valid before full start pair");
	a_early_dv_j: assert property (@(posedge CLOCK) disable iff (!RST_B)
		SYM_VALID && rx_state_r == PRTC_RX_IDLE &&
		SYM == prtc_pkg::PRTC_SYM_J && cfg.early_rxdv |=> rx_dv_r)
		else $error("early receive valid missing");
	a_false_start_err: assert property (@(posedge CLOCK) disable iff (!RST_B)
		SYM_VALID && rx_state_r == PRTC_RX_GOT_J && rx_dv_r &&
		SYM != prtc_pkg::PRTC_SYM_K |=> rx_er_r)
		else $error("false start not flagged");
	a_forced_fdx: assert property (@(posedge CLOCK) disable iff (!RST_B)
		cfg.ext_fdx && PARTNER_FORCED_100TX && !FORCED_MODE |=> fdx_r)
		else $error("forced partner not full duplex");
	a_ieee_fdx: assert property (@(posedge CLOCK) disable iff (!RST_B)
		!cfg.ext_fdx |=> fdx_r == $past(IEEE_FULL_DUPLEX))
		else $error("duplex not from standard resolution");
	a_idle_err_off: assert property (@(posedge CLOCK) disable iff (!RST_B)
		SYM_VALID && rx_state_r == PRTC_RX_IDLE &&
		SYM == prtc_pkg::PRTC_SYM_BAD |=> rx_er_r == $past(cfg.idle_err))
		else $error("idle symbol error handling wrong");
	a_reserved_zero: assert property (@(posedge CLOCK) disable iff (!RST_B)
		(control_one_r & ~prtc_pkg::MASK_ONE) == 16'h0000 &&
		(control_two_r & ~prtc_pkg::MASK_TWO) == 16'h0000)
		else $error("reserved bit set");
endmodule : prtc_ctrl

// ===== prtc_mac_model.sv
// MAC transmit side model that drives frames into the control bank
`timescale 1ns/10ps
module prtc_mac_model (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic start,
	input wire logic [3:0] len,
	input wire logic mark,
	output logic tx_en,
	output logic tx_er
);
	logic [3:0] left_r; // Cycles of the frame still to send
	logic mark_r; // Flag the last cycle of this frame as an error
	// Load a frame length on start, then count it down once per cycle
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			left_r <= 4'h0;
			mark_r <= 1'b0;
		end else if (start) begin
			left_r <= len;
			mark_r <= mark;
		end else if (left_r != 4'h0) begin
			left_r <= left_r - 4'h1;
		end
	end
	// Enable comes from a register, so it only moves just after an edge
	assign tx_en = (left_r != 4'h0);
	// A marked frame carries an error on its last enable cycle only
	assign tx_er = mark_r && (left_r == 4'h1);
endmodule : prtc_mac_model

// ===== prtc_ctrl_tb_top.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
module prtc_ctrl_tb_top;
	logic CLOCK, RST_B, WR, RD, LINK_UP, CABLE_TEST_START, ROBUST_CROSSOVER_EN;
	logic FORCED_MODE, LOCAL_100TX, PARTNER_FORCED_100TX, IEEE_FULL_DUPLEX;
	logic FULL_DUPLEX, SYM_VALID, RX_DV, RX_ER, TX_EN_IN, TX_ER_IN;
	logic TX_EN_OUT, TX_ER_OUT, start, rd_q, mark;
	logic [4:0] ADDR;
	logic [15:0] WDATA, RDATA;
	logic [3:0] len;
	prtc_pkg::prtc_sym_t SYM;
	logic [15:0] exp_q[$]; // Expected read data, oldest first
	logic [31:0] seed;
	int num_errors, n_checks, en_n, er_n, st_n, cyc;
	prtc_ctrl u_dut (.CLOCK(CLOCK), .RST_B(RST_B), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LINK_UP(LINK_UP),
		.CABLE_TEST_START(CABLE_TEST_START),
		.ROBUST_CROSSOVER_EN(ROBUST_CROSSOVER_EN),
		.FORCED_MODE(FORCED_MODE), .LOCAL_100TX(LOCAL_100TX),
		.PARTNER_FORCED_100TX(PARTNER_FORCED_100TX),
		.IEEE_FULL_DUPLEX(IEEE_FULL_DUPLEX), .FULL_DUPLEX(FULL_DUPLEX),
		.SYM_VALID(SYM_VALID), .SYM(SYM), .RX_DV(RX_DV), .RX_ER(RX_ER),
		.TX_EN_IN(TX_EN_IN), .TX_ER_IN(TX_ER_IN), .TX_EN_OUT(TX_EN_OUT),
		.TX_ER_OUT(TX_ER_OUT));
	prtc_mac_model u_mac (.clock(CLOCK), .rst_b(RST_B), .start(start),
		.len(len), .mark(mark), .tx_en(TX_EN_IN), .tx_er(TX_ER_IN));
	// Free-running bench clock, 8 ns period
	initial begin
		CLOCK = 1'b0;
		forever #4 CLOCK = ~CLOCK;
	end
	// Xorshift step for register write data
	function logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		y = y ^ (y << 5);
		return y;
	endfunction : xs
	// Compare one value and count it
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Verdict and end of run
	task final_report;
		if (num_errors == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// One-cycle register write
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge CLOCK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLOCK);
		WR <= 1'b0;
	endtask : wr
	// One-cycle register read; the monitor checks the answer
	task rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge CLOCK);
		ADDR <= a;
		RD <= 1'b1;
		exp_q.push_back(e);
		@(posedge CLOCK);
		RD <= 1'b0;
	endtask : rd
	// Hand one symbol to the receive logic, look at the outputs after
	task sym(input prtc_pkg::prtc_sym_t s, input logic dv, input logic er);
		@(posedge CLOCK);
		SYM_VALID <= 1'b1;
		SYM <= s;
		@(posedge CLOCK);
		SYM_VALID <= 1'b0;
		#1;
		chk("rx_dv", 16'(dv), 16'(RX_DV));
		chk("rx_er", 16'(er), 16'(RX_ER));
	endtask : sym
	// Send a frame of n cycles and count what leaves the transmit side
	task txf(input logic [3:0] n, input logic m, input int e_en,
		input int e_er);
		int en0, er0;
		en0 = en_n;
		er0 = er_n;
		@(posedge CLOCK);
		start <= 1'b1;
		len <= n;
		mark <= m;
		@(posedge CLOCK);
		start <= 1'b0;
		repeat (12) @(posedge CLOCK);
		chk("tx_en cycles", 16'(e_en), 16'(en_n - en0));
		chk("tx_er cycles", 16'(e_er), 16'(er_n - er0));
	endtask : txf
	// Output monitor: read data the cycle after RD, and pulse counts
	always @(posedge CLOCK) begin
		if (rd_q) begin
			chk("rdata", exp_q.pop_front(), RDATA);
		end
		rd_q <= RD;
		en_n += int'(TX_EN_OUT);
		er_n += int'(TX_ER_OUT);
		st_n += int'(CABLE_TEST_START);
	end
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge CLOCK) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			final_report;
		end
	end
	// Main sequence
	initial begin
		int s0;
		{RST_B, WR, RD, rd_q, start, mark, len, ADDR, WDATA, SYM_VALID} = '0;
		{FORCED_MODE, LOCAL_100TX, PARTNER_FORCED_100TX} = '0;
		{IEEE_FULL_DUPLEX, LINK_UP} = 2'b01;
		SYM = prtc_pkg::PRTC_SYM_IDLE;
		seed = 32'hEC60;
		repeat (2) @(posedge CLOCK);
		RST_B <= 1'b1;
		rd(prtc_pkg::OFS_CONTROL_ONE, prtc_pkg::RST_CONTROL);
		rd(prtc_pkg::OFS_CONTROL_TWO, prtc_pkg::RST_CONTROL);
		wr(prtc_pkg::OFS_CONTROL_ONE, 16'hFFFF);
		wr(prtc_pkg::OFS_CONTROL_TWO, 16'hFFFF);
		rd(prtc_pkg::OFS_CONTROL_ONE, prtc_pkg::MASK_ONE);
		rd(prtc_pkg::OFS_CONTROL_TWO, prtc_pkg::MASK_TWO);
		rd(5'h0B, 16'h0000);
		for (int i = 0; i < 8; i++) begin
			seed = xs(seed);
			wr(prtc_pkg::OFS_CONTROL_ONE, seed[15:0]);
			wr(prtc_pkg::OFS_CONTROL_TWO, seed[31:16]);
			rd(prtc_pkg::OFS_CONTROL_ONE, seed[15:0] & prtc_pkg::MASK_ONE);
			rd(prtc_pkg::OFS_CONTROL_TWO, seed[31:16] & prtc_pkg::MASK_TWO);
		end
		// Crossover enable follows its bit both ways
		for (int b = 0; b < 2; b++) begin
			wr(prtc_pkg::OFS_CONTROL_ONE, 16'(b << 5));
			#1;
			chk("robust", 16'(b), 16'(ROBUST_CROSSOVER_EN));
		end
		// Link drop with autorun off, then on: exactly one start pulse
		for (int b = 0; b < 2; b++) begin
			wr(prtc_pkg::OFS_CONTROL_ONE, 16'(b << 8));
			s0 = st_n;
			@(posedge CLOCK);
			LINK_UP <= 1'b0;
			repeat (6) @(posedge CLOCK);
			chk("cable_start", 16'(b), 16'(st_n - s0));
			LINK_UP <= 1'b1;
		end
		// Forced mode is used below, so crossover resolution goes on first
		wr(prtc_pkg::OFS_CONTROL_ONE, 16'h0020);
		// Every duplex input combination, extended bit off and on
		for (int i = 0; i < 32; i++) begin
			wr(prtc_pkg::OFS_CONTROL_TWO, 16'(i[4]) << 5);
			{IEEE_FULL_DUPLEX, PARTNER_FORCED_100TX} <= i[3:2];
			{LOCAL_100TX, FORCED_MODE} <= i[1:0];
			repeat (3) @(posedge CLOCK);
			#1;
			chk("full_duplex", 16'((i[4] & i[2] & (!i[0] | i[1])) | i[3]),
				16'(FULL_DUPLEX));
		end
		// Receive start in normal mode, then in early mode
		wr(prtc_pkg::OFS_CONTROL_TWO, 16'h0000);
		wr(prtc_pkg::OFS_CONTROL_ONE, 16'h0000);
		sym(prtc_pkg::PRTC_SYM_J, 1'b0, 1'b0);
		sym(prtc_pkg::PRTC_SYM_K, 1'b1, 1'b0);
		sym(prtc_pkg::PRTC_SYM_BAD, 1'b1, 1'b1);
		sym(prtc_pkg::PRTC_SYM_END, 1'b0, 1'b0);
		wr(prtc_pkg::OFS_CONTROL_ONE, 16'h0002);
		sym(prtc_pkg::PRTC_SYM_J, 1'b1, 1'b0);
		sym(prtc_pkg::PRTC_SYM_K, 1'b1, 1'b0);
		sym(prtc_pkg::PRTC_SYM_END, 1'b0, 1'b0);
		sym(prtc_pkg::PRTC_SYM_J, 1'b1, 1'b0);
		sym(prtc_pkg::PRTC_SYM_DATA, 1'b0, 1'b1);
		sym(prtc_pkg::PRTC_SYM_IDLE, 1'b0, 1'b0);
		// Bad symbol while idle, flag off then on
		sym(prtc_pkg::PRTC_SYM_BAD, 1'b0, 1'b0);
		wr(prtc_pkg::OFS_CONTROL_TWO, 16'h0004);
		sym(prtc_pkg::PRTC_SYM_BAD, 1'b0, 1'b1);
		// Odd and even frames with the check on, odd frame with it off
		wr(prtc_pkg::OFS_CONTROL_TWO, 16'h0000);
		txf(4'h3, 1'b0, 4, 1);
		txf(4'h4, 1'b0, 4, 0);
		txf(4'h4, 1'b1, 4, 1);
		wr(prtc_pkg::OFS_CONTROL_TWO, 16'h0002);
		txf(4'h3, 1'b0, 3, 0);
		// Reset in mid-run must bring both nonzero registers back to zero
		@(posedge CLOCK);
		RST_B <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RST_B <= 1'b1;
		rd(prtc_pkg::OFS_CONTROL_ONE, prtc_pkg::RST_CONTROL);
		rd(prtc_pkg::OFS_CONTROL_TWO, prtc_pkg::RST_CONTROL);
		// Let the monitor take the last read answer before the verdict
		repeat (2) @(posedge CLOCK);
		final_report;
	end
endmodule : prtc_ctrl_tb_top
